// ==== ccu_pkg.sv ====
// shared constants and types of the capture/compare unit
`default_nettype none
package ccu_pkg;
  // register indices; the byte address is four times the index
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam logic [7:0] IDX_INTCTL = 8'h0B;
  localparam logic [7:0] IDX_FLAGS1 = 8'h0C;
  localparam logic [7:0] IDX_FLAGS2 = 8'h0D;
  localparam logic [7:0] IDX_TMR_LO = 8'h0E;
  localparam logic [7:0] IDX_TMR_HI = 8'h0F;
  localparam logic [7:0] IDX_TMR_CTL = 8'h10;
  localparam logic [7:0] IDX_U1_LO = 8'h15;
  localparam logic [7:0] IDX_U1_HI = 8'h16;
  localparam logic [7:0] IDX_U1_CTL = 8'h17;
  localparam logic [7:0] IDX_U2_LO = 8'h1B;
  localparam logic [7:0] IDX_U2_HI = 8'h1C;
  localparam logic [7:0] IDX_U2_CTL = 8'h1D;
  localparam logic [7:0] IDX_CONV = 8'h20;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_ENA1 = 8'h8C;
  localparam logic [7:0] IDX_ENA2 = 8'h8D;
  // field positions
  localparam int U1_FLAG_BIT = 2;
  localparam int OVF_BIT = 0;
  localparam int U2_FLAG_BIT = 0;
  localparam int TMR_ON_BIT = 0;
  localparam int CKPS_LSB = 4;
  localparam int CONV_ON_BIT = 0;
  localparam int CONV_GO_BIT = 2;
  localparam int PIN1_DIR_BIT = 2;
  localparam int PIN2_DIR_BIT = 1;
  // reset values and masks
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] TMR_CTL_MASK = 8'h3F;
  localparam logic [7:0] FLAGS2_MASK = 8'h01;
  // unit mode field encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SW = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  localparam logic [1:0] GRP_CAP = 2'h1;
  localparam logic [1:0] GRP_CMP = 2'h2;
  localparam logic [3:0] PRE_4_LAST = 4'h3;
  localparam logic [3:0] PRE_16_LAST = 4'hF;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // write channel states, gray along both paths
  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_ADDR = 2'h1,
    W_DATA = 2'h2,
    W_RESP = 2'h3
  } ccu_wst_t;
endpackage
`default_nettype wire

// ==== ccu_unit_if.sv ====
// link between the register block and one capture/compare unit
`default_nettype none
interface ccu_unit_if #(parameter int W = 16);
  logic [W-1:0] tmr;
  logic pin_s;
  logic wr_lo;
  logic wr_hi;
  logic wr_ctl;
  logic [7:0] wdata;
  logic [W-1:0] value;
  logic [5:0] ctl;
  logic out_q;
  logic evt;
  logic trig;
  modport host (output tmr, pin_s, wr_lo, wr_hi, wr_ctl, wdata,
                input value, ctl, out_q, evt, trig);
  modport unit (input tmr, pin_s, wr_lo, wr_hi, wr_ctl, wdata,
                output value, ctl, out_q, evt, trig);
endinterface
`default_nettype wire

// ==== ccu_sync.sv ====
// two-stage synchroniser for pin inputs
`default_nettype none
module ccu_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ccu_sync_st_t;
  ccu_sync_st_t st_ff;
  ccu_sync_st_t nxt_st;
  // first stage feeds only the second
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule // ccu_sync
`default_nettype wire

// ==== ccu_unit.sv ====
// one capture/compare unit: prescaler, capture, compare, output latch
`default_nettype none
module ccu_unit #(parameter int W = 16) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to the register block
  ccu_unit_if.unit u
);
  typedef struct packed {
    logic [W-1:0] value;
    logic [5:0] ctl;
    logic out_q;
    logic [3:0] pre;
    logic pin_q;
    logic eq_q;
  } ccu_unit_st_t;
  ccu_unit_st_t st_ff;
  ccu_unit_st_t nxt_st;
  logic [3:0] mode;
  logic cap_mode;
  logic hit;
  logic cap;
  logic rise;
  logic eq;

  if (W != 16) begin : g_chk
    $error("ccu_unit serves a 16-bit value only");
  end

  always_comb begin
    nxt_st = st_ff;
    mode = st_ff.ctl[3:0];
    cap_mode = (mode[3:2] == ccu_pkg::GRP_CAP);
    rise = u.pin_s & ~st_ff.pin_q;
    eq = (u.tmr == st_ff.value); // [R5]
    hit = (mode[3:2] == ccu_pkg::GRP_CMP) & eq & ~st_ff.eq_q; // [R18]
    cap = 1'b0;
    nxt_st.pin_q = u.pin_s;
    nxt_st.eq_q = eq;
    // count survives a switch between capture settings: first capture may be early
    case (mode)
      ccu_pkg::MODE_CAP_FALL: cap = ~u.pin_s & st_ff.pin_q; // [R15]
      ccu_pkg::MODE_CAP_RISE: cap = rise; // [R15]
      ccu_pkg::MODE_CAP_4, ccu_pkg::MODE_CAP_16: begin
        if (rise) begin
          if (st_ff.pre >= ((mode == ccu_pkg::MODE_CAP_4) ? ccu_pkg::PRE_4_LAST
                                                          : ccu_pkg::PRE_16_LAST)) begin
            cap = 1'b1; // [R3] [R15]
            nxt_st.pre = 4'h0;
          end else begin
            nxt_st.pre = st_ff.pre + 4'h1;
          end
        end
      end
      default: nxt_st.pre = 4'h0; // [R1]
    endcase
    if (hit && mode == ccu_pkg::MODE_CMP_SET) nxt_st.out_q = 1'b1; // [R6] [R14]
    if (hit && mode == ccu_pkg::MODE_CMP_CLR) nxt_st.out_q = 1'b0; // [R6] [R14]
    if (u.wr_lo) nxt_st.value[7:0] = u.wdata;
    if (u.wr_hi) nxt_st.value[15:8] = u.wdata;
    if (u.wr_ctl) begin
      nxt_st.ctl = u.wdata[5:0];
      if (u.wdata[3:0] == ccu_pkg::MODE_OFF) begin
        nxt_st.out_q = 1'b0; // [R10] [R16]
        nxt_st.pre = 4'h0; // [R4] [R16]
      end
    end
    // a capture beats a software write of the value in the same cycle
    if (cap) nxt_st.value = u.tmr; // [R17]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0; // [R2]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign u.value = st_ff.value;
  assign u.ctl = st_ff.ctl;
  assign u.out_q = st_ff.out_q;
  assign u.evt = hit | cap; // [R6] [R11] [R17]
  assign u.trig = hit & (mode == ccu_pkg::MODE_CMP_TRIG); // [R7] [R9]

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  presc_clear_a: assert property ( // [R1]
    !cap_mode |=> st_ff.pre == 4'h0)
    else $error("prescaler kept count outside capture");
  match_once_a: assert property ( // [R18]
    hit |=> !hit)
    else $error("compare match acted twice");
  zero_ctl_a: assert property ( // [R10]
    u.wr_ctl && u.wdata[3:0] == ccu_pkg::MODE_OFF |=> !st_ff.out_q && st_ff.pre == 4'h0)
    else $error("zero control did not clear latch");
  cap_copy_a: assert property ( // [R17]
    cap |=> st_ff.value == $past(u.tmr))
    else $error("capture did not copy timer");
  sw_pin_a: assert property ( // [R11]
    hit && mode == ccu_pkg::MODE_CMP_SW && !u.wr_ctl |=> st_ff.out_q == $past(st_ff.out_q))
    else $error("software event mode moved the pin");
  cap16_c: cover property (cap && mode == ccu_pkg::MODE_CAP_16);
endmodule // ccu_unit
`default_nettype wire

// ==== ccu_top.sv ====
// capture/compare block: bus slave, base timer and two units
//
// Functional notes
// R1 - prescaler clears when unit off or not capture
// R2 - every reset clears the prescaler
// R3 - capture setting change keeps prescaler count
// R4 - software writes zero before new capture setting
// R5 - compare value against timer continuously
// R6 - match drives pin and sets event flag
// R7 - trigger clears timer, no overflow flag
// R8 - second unit trigger sets converter go bit
// R9 - value register acts as timer period
// R10 - zero control write forces output latch low
// R11 - software mode: flag only, pin untouched
// R12 - software runs timer synchronously for compare
// R13 - software clears direction bit for output
// R14 - compare encodings: set, clear, soft, trigger
// R15 - capture encodings: fall, rise, four, sixteen
// R16 - mode zero disables and resets unit
// R17 - capture copies timer and sets flag
// R18 - flag sticky; match acts once per equality
// R19 - pin edges synchronised before detection
`default_nettype none
module ccu_top #(
  parameter int ADDR_W = 12,
  parameter int TMR_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // unit one pin
  input wire logic unit_one_pin_i,
  output logic unit_one_pin_o,
  output logic unit_one_pin_oe,
  // unit two pin
  input wire logic unit_two_pin_i,
  output logic unit_two_pin_o,
  output logic unit_two_pin_oe,
  // converter start request
  output logic converter_go
);
  typedef struct packed {
    ccu_pkg::ccu_wst_t wst;
    logic awready;
    logic wready;
    logic [7:0] waddr;
    logic [7:0] wdat;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] intctl;
    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [7:0] ena1;
    logic [7:0] ena2;
    logic [7:0] tmr_ctl;
    logic [TMR_W-1:0] tmr;
    logic [2:0] div;
    logic [7:0] dir_c;
    logic [7:0] conv;
    logic oe1;
    logic oe2;
  } ccu_top_st_t;

  ccu_top_st_t st_ff;
  ccu_top_st_t nxt;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic [7:0] wd;
  logic [2:0] pmask;
  logic tick;
  logic trig;
  logic [1:0] pin_s;

  if (ADDR_W < ccu_pkg::IDX_W + ccu_pkg::IDX_LSB) begin : g_chk_addr
    $error("ccu_top address too narrow for the register map");
  end
  if (TMR_W != 16) begin : g_chk_tmr
    $error("ccu_top serves a 16-bit base timer only");
  end

  // known register indices; both bus directions answer from this
  function automatic logic reg_known(input logic [7:0] idx);
    case (idx)
      ccu_pkg::IDX_INTCTL, ccu_pkg::IDX_FLAGS1, ccu_pkg::IDX_FLAGS2,
      ccu_pkg::IDX_TMR_LO, ccu_pkg::IDX_TMR_HI, ccu_pkg::IDX_TMR_CTL,
      ccu_pkg::IDX_U1_LO, ccu_pkg::IDX_U1_HI, ccu_pkg::IDX_U1_CTL,
      ccu_pkg::IDX_U2_LO, ccu_pkg::IDX_U2_HI, ccu_pkg::IDX_U2_CTL,
      ccu_pkg::IDX_CONV, ccu_pkg::IDX_DIR_C, ccu_pkg::IDX_ENA1,
      ccu_pkg::IDX_ENA2: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  ccu_unit_if #(.W(TMR_W)) u1();
  ccu_unit_if #(.W(TMR_W)) u2();

  ccu_sync #(.W(2)) i_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({unit_two_pin_i, unit_one_pin_i}), // [R19]
    .q(pin_s)
  );

  ccu_unit #(.W(TMR_W)) i_unit_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .u(u1.unit)
  );

  ccu_unit #(.W(TMR_W)) i_unit_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .u(u2.unit)
  );

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt = st_ff;
    aw_hs = awvalid & st_ff.awready;
    w_hs = wvalid & st_ff.wready;
    ar_hs = arvalid & st_ff.arready;
    wr = 1'b0;
    ridx = araddr[ccu_pkg::IDX_LSB +: ccu_pkg::IDX_W];
    // write channel: address and data taken in either order
    if (aw_hs) begin
      nxt.waddr = awaddr[ccu_pkg::IDX_LSB +: ccu_pkg::IDX_W];
      nxt.awready = 1'b0;
    end
    if (w_hs) begin
      nxt.wdat = wdata[7:0];
      nxt.wen = wstrb[0];
      nxt.wready = 1'b0;
    end
    case (st_ff.wst)
      ccu_pkg::W_IDLE, ccu_pkg::W_ADDR, ccu_pkg::W_DATA: begin
        if (!nxt.awready && !nxt.wready) begin
          wr = nxt.wen;
          nxt.wst = ccu_pkg::W_RESP;
          nxt.bvalid = 1'b1;
          nxt.bresp = reg_known(nxt.waddr) ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
        end else if (!nxt.awready) begin
          nxt.wst = ccu_pkg::W_ADDR;
        end else if (!nxt.wready) begin
          nxt.wst = ccu_pkg::W_DATA;
        end
      end
      ccu_pkg::W_RESP: begin
        if (bready) begin
          nxt.bvalid = 1'b0;
          nxt.awready = 1'b1;
          nxt.wready = 1'b1;
          nxt.wst = ccu_pkg::W_IDLE;
        end
      end
      default: nxt.wst = ccu_pkg::W_IDLE;
    endcase
    widx = nxt.waddr;
    wd = nxt.wdat;

    // read channel: one read at a time, answer one cycle after the take
    if (ar_hs) begin
      nxt.arready = 1'b0;
      nxt.rvalid = 1'b1;
      nxt.rresp = reg_known(ridx) ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
      case (ridx)
        ccu_pkg::IDX_INTCTL: nxt.rdata = st_ff.intctl;
        ccu_pkg::IDX_FLAGS1: nxt.rdata = st_ff.flags1;
        ccu_pkg::IDX_FLAGS2: nxt.rdata = st_ff.flags2;
        ccu_pkg::IDX_TMR_LO: nxt.rdata = st_ff.tmr[7:0];
        ccu_pkg::IDX_TMR_HI: nxt.rdata = st_ff.tmr[15:8];
        ccu_pkg::IDX_TMR_CTL: nxt.rdata = st_ff.tmr_ctl;
        ccu_pkg::IDX_U1_LO: nxt.rdata = u1.value[7:0];
        ccu_pkg::IDX_U1_HI: nxt.rdata = u1.value[15:8];
        ccu_pkg::IDX_U1_CTL: nxt.rdata = {2'h0, u1.ctl};
        ccu_pkg::IDX_U2_LO: nxt.rdata = u2.value[7:0];
        ccu_pkg::IDX_U2_HI: nxt.rdata = u2.value[15:8];
        ccu_pkg::IDX_U2_CTL: nxt.rdata = {2'h0, u2.ctl};
        ccu_pkg::IDX_CONV: nxt.rdata = st_ff.conv;
        ccu_pkg::IDX_DIR_C: nxt.rdata = st_ff.dir_c;
        ccu_pkg::IDX_ENA1: nxt.rdata = st_ff.ena1;
        ccu_pkg::IDX_ENA2: nxt.rdata = st_ff.ena2;
        default: nxt.rdata = ccu_pkg::REG_RST;
      endcase
    end else if (st_ff.rvalid && rready) begin
      nxt.rvalid = 1'b0;
      nxt.arready = 1'b1;
    end

    // unit links
    u1.tmr = st_ff.tmr;
    u2.tmr = st_ff.tmr;
    u1.pin_s = pin_s[0];
    u2.pin_s = pin_s[1];
    u1.wdata = wd;
    u2.wdata = wd;
    u1.wr_lo = wr && widx == ccu_pkg::IDX_U1_LO;
    u1.wr_hi = wr && widx == ccu_pkg::IDX_U1_HI;
    u1.wr_ctl = wr && widx == ccu_pkg::IDX_U1_CTL;
    u2.wr_lo = wr && widx == ccu_pkg::IDX_U2_LO;
    u2.wr_hi = wr && widx == ccu_pkg::IDX_U2_HI;
    u2.wr_ctl = wr && widx == ccu_pkg::IDX_U2_CTL;

    // register writes from software
    if (wr) begin
      case (widx)
        ccu_pkg::IDX_INTCTL: nxt.intctl = wd;
        ccu_pkg::IDX_FLAGS1: nxt.flags1 = wd;
        ccu_pkg::IDX_FLAGS2: nxt.flags2 = wd & ccu_pkg::FLAGS2_MASK;
        ccu_pkg::IDX_TMR_LO: nxt.tmr[7:0] = wd;
        ccu_pkg::IDX_TMR_HI: nxt.tmr[15:8] = wd;
        ccu_pkg::IDX_TMR_CTL: nxt.tmr_ctl = wd & ccu_pkg::TMR_CTL_MASK;
        ccu_pkg::IDX_CONV: nxt.conv = wd;
        ccu_pkg::IDX_DIR_C: nxt.dir_c = wd;
        ccu_pkg::IDX_ENA1: nxt.ena1 = wd;
        ccu_pkg::IDX_ENA2: nxt.ena2 = wd & ccu_pkg::FLAGS2_MASK;
        default: nxt.conv = nxt.conv;
      endcase
    end

    // base timer, prescaled 1/2/4/8 by a free divider enable
    pmask = 3'((4'h1 << st_ff.tmr_ctl[ccu_pkg::CKPS_LSB +: 2]) - 4'h1);
    tick = st_ff.tmr_ctl[ccu_pkg::TMR_ON_BIT] && ((st_ff.div & pmask) == pmask);
    trig = u1.trig | u2.trig;
    if (st_ff.tmr_ctl[ccu_pkg::TMR_ON_BIT]) nxt.div = st_ff.div + 3'h1;
    // a software timer write beats the increment, or a running timer could never be loaded
    if (tick && !(wr && (widx == ccu_pkg::IDX_TMR_LO || widx == ccu_pkg::IDX_TMR_HI))) begin
      nxt.tmr = st_ff.tmr + 16'h0001;
      if (st_ff.tmr == 16'hFFFF && !trig) nxt.flags1[ccu_pkg::OVF_BIT] = 1'b1;
    end
    // trigger beats both the increment and a software timer write
    if (trig) nxt.tmr = '0; // [R7] [R9]

    // hardware sets win over a software clear in the same cycle
    if (u1.evt) nxt.flags1[ccu_pkg::U1_FLAG_BIT] = 1'b1; // [R6] [R18]
    if (u2.evt) nxt.flags2[ccu_pkg::U2_FLAG_BIT] = 1'b1; // [R6] [R18]
    if (u2.trig && st_ff.conv[ccu_pkg::CONV_ON_BIT]) begin
      nxt.conv[ccu_pkg::CONV_GO_BIT] = 1'b1; // [R8]
    end

    // pin drivers follow the port direction bits; compare needs them clear
    nxt.oe1 = ~nxt.dir_c[ccu_pkg::PIN1_DIR_BIT]; // [R13]
    nxt.oe2 = ~nxt.dir_c[ccu_pkg::PIN2_DIR_BIT]; // [R13]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.wst <= ccu_pkg::W_IDLE;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.dir_c <= ccu_pkg::DIR_RST;
    end else begin
      st_ff <= nxt;
    end
  end

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rresp = st_ff.rresp;
  assign rdata = {24'h000000, st_ff.rdata};
  assign unit_one_pin_o = u1.out_q;
  assign unit_two_pin_o = u2.out_q;
  assign unit_one_pin_oe = st_ff.oe1;
  assign unit_two_pin_oe = st_ff.oe2;
  assign converter_go = st_ff.conv[ccu_pkg::CONV_GO_BIT];

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  trig_clear_a: assert property ( // [R7]
    trig |=> st_ff.tmr == 16'h0000)
    else $error("trigger did not clear timer");
  trig_noovf_a: assert property ( // [R7]
    trig && !st_ff.flags1[ccu_pkg::OVF_BIT] && !(wr && widx == ccu_pkg::IDX_FLAGS1)
    |=> !st_ff.flags1[ccu_pkg::OVF_BIT])
    else $error("trigger raised overflow flag");
  go_start_a: assert property ( // [R8]
    u2.trig && st_ff.conv[ccu_pkg::CONV_ON_BIT] |=> converter_go)
    else $error("converter not started by trigger");
  go_idle_a: assert property ( // [R8]
    !u2.trig && !converter_go && !(wr && widx == ccu_pkg::IDX_CONV) |=> !converter_go)
    else $error("converter started without trigger");
  flag_set_a: assert property ( // [R6]
    u1.evt |=> st_ff.flags1[ccu_pkg::U1_FLAG_BIT])
    else $error("unit one event flag not set");
  flag_hold_a: assert property ( // [R18]
    st_ff.flags2[ccu_pkg::U2_FLAG_BIT] && !(wr && widx == ccu_pkg::IDX_FLAGS2)
    |=> st_ff.flags2[ccu_pkg::U2_FLAG_BIT])
    else $error("unit two flag dropped without software");
  pin_dir_a: assert property ( // [R13]
    wr && widx == ccu_pkg::IDX_DIR_C |=> unit_one_pin_oe == !$past(wd[ccu_pkg::PIN1_DIR_BIT]))
    else $error("pin enable does not follow direction");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response withdrawn");
  trig_c: cover property (trig ##1 st_ff.tmr == 16'h0000);
  write_c: cover property (awvalid && awready && wvalid && wready ##1 bvalid);
  read_c: cover property (arvalid && arready ##1 rvalid);
endmodule // ccu_top
`default_nettype wire

// ==== ccu_pin_model.sv ====
// external signal source that drives edges onto a unit pin
`default_nettype none
module ccu_pin_model (
  // clock
  input wire logic aclk,
  // request from the bench
  input wire logic start,
  input wire logic [4:0] n_edges,
  // pin side
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // four cycles each way keeps every level well past the two-flop synchroniser
  always begin
    @(posedge aclk);
    if (start) begin
      busy <= 1'b1;
      repeat (n_edges) begin
        repeat (4) @(posedge aclk);
        pin <= 1'b1;
        repeat (4) @(posedge aclk);
        pin <= 1'b0;
      end
      // settle so the last edge has reached the unit before busy drops
      repeat (6) @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule // ccu_pin_model
`default_nettype wire

// ==== ccu_top_tb.sv ====
// self-checking testbench of the capture/compare block
`default_nettype none
module ccu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, start, busy, pin1;
  logic awready, wready, bvalid, arready, rvalid, p1o, p1oe, p2o, p2oe, go;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [4:0] n_edges;
  logic [7:0] d;
  logic [3:0] cm [4];
  logic cp [4];
  int miscompares, num_checks;
  ccu_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .unit_one_pin_i(pin1), .unit_one_pin_o(p1o), .unit_one_pin_oe(p1oe),
    .unit_two_pin_i(1'b0), .unit_two_pin_o(p2o), .unit_two_pin_oe(p2oe),
    .converter_go(go));
  ccu_pin_model pm (.aclk(aclk), .start(start), .n_edges(n_edges), .pin(pin1), .busy(busy));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // write and address are offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] idx);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic poll(input logic [7:0] idx, input int b);
    for (int i = 0; i < 300; i++) begin
      rd(idx);
      if (d[b] === 1'b1) break;
    end
  endtask
  task automatic pulses(input logic [4:0] n);
    n_edges <= n;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
  endtask
  // zero first, then the new setting, so the prescaler starts from nothing
  task automatic cap(input logic [3:0] m, input logic [4:0] k);
    wr(ccu_pkg::IDX_U1_CTL, 8'h00);
    wr(ccu_pkg::IDX_U1_CTL, {4'h0, m});
    wr(ccu_pkg::IDX_FLAGS1, 8'h00);
    if (k > 5'h01) begin
      pulses(k - 5'h01);
      rd(ccu_pkg::IDX_FLAGS1);
      chk(d, 8'h00);
    end
    pulses(5'h01);
    rd(ccu_pkg::IDX_FLAGS1);
    chk(d, 8'h04);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, start} = 5'h00;
    // answers are always accepted, so back-to-back calls never lower and raise a ready
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, wstrb, n_edges} = {12'h000, 12'h000, 32'h0, 4'hF, 5'h00};
    miscompares = 0;
    num_checks = 0;
    cm = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_SW, ccu_pkg::MODE_CMP_CLR,
           ccu_pkg::MODE_CMP_SET};
    cp = '{1'b1, 1'b1, 1'b0, 1'b1};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ccu_pkg::IDX_U1_CTL);
    chk(d, ccu_pkg::REG_RST);
    rd(ccu_pkg::IDX_DIR_C);
    chk(d, ccu_pkg::DIR_RST);
    chk({6'h00, r}, {6'h00, ccu_pkg::RESP_OKAY});
    rd(8'h40);
    chk({6'h00, r}, {6'h00, ccu_pkg::RESP_SLVERR});
    wr(8'h40, 8'h5A);
    chk({6'h00, r}, {6'h00, ccu_pkg::RESP_SLVERR});
    $display("test reset done");
    wr(ccu_pkg::IDX_DIR_C, 8'hF9);
    chk({6'h00, r}, {6'h00, ccu_pkg::RESP_OKAY});
    wr(ccu_pkg::IDX_U1_LO, 8'h30);
    wr(ccu_pkg::IDX_U1_HI, 8'h00);
    wr(ccu_pkg::IDX_TMR_CTL, 8'h01);
    // sw keeps the latch high, clear drops it, set raises it again
    foreach (cm[i]) begin
      wr(ccu_pkg::IDX_U1_CTL, {4'h0, cm[i]});
      wr(ccu_pkg::IDX_FLAGS1, 8'h00);
      wr(ccu_pkg::IDX_TMR_LO, 8'h00);
      poll(ccu_pkg::IDX_FLAGS1, ccu_pkg::U1_FLAG_BIT);
      chk(d, 8'h04);
      chk({7'h00, p1o}, {7'h00, cp[i]});
    end
    chk({7'h00, p1oe}, 8'h01);
    chk({7'h00, p2oe}, 8'h01);
    rd(ccu_pkg::IDX_FLAGS1);
    chk(d, 8'h04);
    wr(ccu_pkg::IDX_FLAGS1, 8'h00);
    rd(ccu_pkg::IDX_FLAGS1);
    chk(d, 8'h00);
    wr(ccu_pkg::IDX_U1_CTL, 8'h00);
    chk({7'h00, p1o}, 8'h00);
    $display("test compare done");
    wr(ccu_pkg::IDX_U2_LO, 8'h40);
    wr(ccu_pkg::IDX_U2_HI, 8'h00);
    wr(ccu_pkg::IDX_CONV, 8'h00);
    wr(ccu_pkg::IDX_U2_CTL, {4'h0, ccu_pkg::MODE_CMP_TRIG});
    wr(ccu_pkg::IDX_FLAGS2, 8'h00);
    // the free-running timer is past the period by now; restart it below the match
    wr(ccu_pkg::IDX_TMR_LO, 8'h00);
    poll(ccu_pkg::IDX_FLAGS2, ccu_pkg::U2_FLAG_BIT);
    chk({7'h00, go}, 8'h00);
    wr(ccu_pkg::IDX_CONV, 8'h01);
    wr(ccu_pkg::IDX_FLAGS2, 8'h00);
    poll(ccu_pkg::IDX_FLAGS2, ccu_pkg::U2_FLAG_BIT);
    chk({7'h00, go}, 8'h01);
    chk({7'h00, p2o}, 8'h00);
    rd(ccu_pkg::IDX_TMR_HI);
    chk(d, 8'h00);
    rd(ccu_pkg::IDX_TMR_LO);
    chk({7'h00, d < 8'h42}, 8'h01);
    // period at the top of the range: the trigger must beat the overflow
    wr(ccu_pkg::IDX_U2_LO, 8'hFF);
    wr(ccu_pkg::IDX_U2_HI, 8'hFF);
    wr(ccu_pkg::IDX_TMR_HI, 8'hFF);
    wr(ccu_pkg::IDX_FLAGS2, 8'h00);
    poll(ccu_pkg::IDX_FLAGS2, ccu_pkg::U2_FLAG_BIT);
    rd(ccu_pkg::IDX_TMR_HI);
    chk(d, 8'h00);
    rd(ccu_pkg::IDX_FLAGS1);
    chk(d, 8'h00);
    wr(ccu_pkg::IDX_U2_CTL, 8'h00);
    $display("test trigger done");
    cap(ccu_pkg::MODE_CAP_FALL, 5'h01);
    cap(ccu_pkg::MODE_CAP_RISE, 5'h01);
    cap(ccu_pkg::MODE_CAP_16, 5'h10);
    // a direct switch keeps the count: three edges in /16, then one edge in /4 captures
    pulses(5'h03);
    wr(ccu_pkg::IDX_U1_CTL, {4'h0, ccu_pkg::MODE_CAP_4});
    wr(ccu_pkg::IDX_FLAGS1, 8'h00);
    pulses(5'h01);
    rd(ccu_pkg::IDX_FLAGS1);
    chk(d, 8'h04);
    cap(ccu_pkg::MODE_CAP_4, 5'h04);
    $display("test capture done");
    results();
  end
endmodule // ccu_top_tb
`default_nettype wire
